/* File: bus_port_pkg.sv */
// Shared constants and types for the bus slave stream port
package bus_port_pkg;

  // Default port geometry
  localparam int DAT_W_DEF = 32;
  localparam int ADR_W_DEF = 8;
  localparam int TAG_W_DEF = 1;

  // Word index of each port location, taken above the byte-lane bits
  localparam int DATA_IDX = 0;
  localparam int STAT_IDX = 1;

  // Status word layout
  localparam int STAT_TXCNT_LSB = 0;
  localparam int STAT_TXCNT_W   = 2;
  localparam int STAT_RXV_BIT   = 4;
  localparam int STAT_TXFULL_BIT = 5;

  // Two-entry buffer between bus writes and the transmit stream
  localparam int BUF_DEPTH = 2;
  localparam int BUF_CNT_W = 2;

  // Reset values
  localparam logic RST_TERM = 1'b0;

  // Port sequencer states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_TERM
  } port_state_t;

  // Termination chosen for an access
  typedef enum logic [1:0] {
    RESP_NONE,
    RESP_ACK,
    RESP_ERR,
    RESP_RTY
  } resp_t;

endpackage

/* File: stream_buf.sv */
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module stream_buf
  import bus_port_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = BUF_DEPTH,
  parameter int PTR_W = $clog2(DEPTH),
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [W-1:0]     in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [W-1:0]     out_data,
  output logic      [CNT_W-1:0] level
);

  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [W-1:0]     mem_r   [DEPTH];
  logic [W-1:0]     mem_nxt [DEPTH];
  logic [PTR_W-1:0] wp_r;
  logic [PTR_W-1:0] wp_nxt;
  logic [PTR_W-1:0] rp_r;
  logic [PTR_W-1:0] rp_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             push;
  logic             pop;

  // Honest full and empty straight from the count
  assign in_ready  = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign level     = cnt_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Each entry loads only when the write pointer selects it
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    assign mem_nxt[i] = (push && wp_r == PTR_W'(i)) ? in_data : mem_r[i];
  end

  // Pointer and count update; flush empties without touching data
  always_comb begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (flush) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end else begin
      if (push) begin
        wp_nxt = (wp_r == LAST_PTR) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_nxt = (rp_r == LAST_PTR) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

endmodule

/* File: bus_slave_port.sv */
// Synchronous bus slave port bridging bus cycles to user streams
//
// Behaviour
// - All bus outputs come from clocked registers
// - Reset forces the sequencer to idle
// - Bus reset clears port logic only
// - Every strobe gets exactly one termination
// - Act only while strobed, reset always
// - Write enable low reads, high writes
// - Address msb at top, lsb by size
// - Port may work without address lines
// - Data width matches port size, max 64
// - Byte selects mark valid data lanes
// - Acknowledge ends cycle normally
// - Error ends cycle abnormally
// - Retry means repeat the cycle later
// - Tags carry user meaning, bus timing
// - Reset synchronous, at least one cycle
// - Never two terminations in one cycle
`timescale 1ns/1ns
module bus_slave_port
  import bus_port_pkg::*;
#(
  parameter int DAT_W    = DAT_W_DEF,
  parameter int ADR_W    = ADR_W_DEF,
  parameter int TAG_W    = TAG_W_DEF,
  parameter bit USE_ADDR = 1'b1,
  parameter int SEL_W    = DAT_W / 8,
  parameter int ADR_LSB  = $clog2(SEL_W)
) (
  // Clock and the two resets
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             rst_i,
  // Bus side, every answer registered
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [DAT_W-1:0] dat_i,
  input  wire logic [SEL_W-1:0] sel_i,
  input  wire logic [TAG_W-1:0] tag_i,
  output logic                  ack_o,
  output logic                  err_o,
  output logic                  rty_o,
  output logic      [DAT_W-1:0] dat_o,
  output logic      [TAG_W-1:0] tag_o,
  // Transmit stream out of the write buffer
  output logic                  tx_valid,
  input  wire logic             tx_ready,
  output logic      [DAT_W-1:0] tx_data,
  output logic      [SEL_W-1:0] tx_sel,
  output logic      [TAG_W-1:0] tx_tag,
  // Receive stream feeding data reads
  input  wire logic             rx_valid,
  output logic                  rx_ready,
  input  wire logic [DAT_W-1:0] rx_data,
  input  wire logic [TAG_W-1:0] rx_tag
);

  // Limitations a user must know:
  //   one access per two cycles; each strobe is answered on its own
  //   a strobe seen during a bus reset is ignored; if it is still
  //   high after the reset it is taken then
  //   the receive source must hold its word until rx_ready is seen
  //   status reads return a zero tag

  // Buffer word packs tag, lanes and data, top down
  localparam int BUF_W = TAG_W + SEL_W + DAT_W;
  // Word index width above the byte-lane bits
  localparam int IDX_W = ADR_W - ADR_LSB;

  // Expand byte selects into a bit mask over the data lanes;
  // shared by the read and write paths so both mask the same lanes
  function automatic logic [DAT_W-1:0] lane_mask(input logic [SEL_W-1:0] sel);
    logic [DAT_W-1:0] m;
    m = '0;
    for (int b = 0; b < SEL_W; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction

  // Sequencer and terminations
  port_state_t      state_r;
  port_state_t      state_nxt;
  logic             ack_r;
  logic             ack_nxt;
  logic             err_r;
  logic             err_nxt;
  logic             rty_r;
  logic             rty_nxt;
  // Read data and tag
  logic [DAT_W-1:0] dat_r;
  logic [DAT_W-1:0] dat_nxt;
  logic [TAG_W-1:0] tag_r;
  logic [TAG_W-1:0] tag_nxt;
  // Access decode
  resp_t            resp;
  logic             hit;
  logic             rd_ack;
  logic             is_data;
  logic             is_stat;
  logic [IDX_W-1:0] word_idx;
  // Write buffer and status
  logic             buf_in_valid;
  logic             buf_in_ready;
  logic [BUF_W-1:0] buf_in_data;
  logic [BUF_W-1:0] buf_out_data;
  logic [BUF_CNT_W-1:0] buf_level;
  logic [DAT_W-1:0] stat_word;

  // Selected only while the cycle is strobed and no answer is pending;
  // the idle gap after each answer keeps one strobe from two answers;
  // a bus reset outranks the strobe, so nothing is pushed or pulled
  assign hit = cyc_i & stb_i & ~rst_i & (state_r == ST_IDLE);

  // Port map, one word per index above the byte-lane bits:
  //   index 0   data; a write pushes the buffer, a read pulls rx
  //   index 1   status, read only
  //   others    refused with an error
  // Without address lines every access goes to the data word, which
  // suits a plain stream port; status is then out of reach.
  // Decode is only read in the cycle the strobe is taken
  if (USE_ADDR) begin : g_decode
    assign word_idx = adr_i[ADR_W-1:ADR_LSB];
    assign is_data  = (word_idx == IDX_W'(DATA_IDX));
    assign is_stat  = (word_idx == IDX_W'(STAT_IDX));
  end else begin : g_no_decode
    assign word_idx = '0;  // Address pins left unread
    assign is_data  = 1'b1;
    assign is_stat  = 1'b0;
  end

  // Status word, read only:
  //   bits 1:0  words waiting in the write buffer
  //   bit 4     receive stream has a word ready
  //   bit 5     write buffer full; writes would be retried
  // Built from live state, so a read shows the value at the taken edge
  always_comb begin
    stat_word = '0;
    stat_word[STAT_TXCNT_LSB +: STAT_TXCNT_W] = buf_level;
    stat_word[STAT_RXV_BIT]    = rx_valid;
    stat_word[STAT_TXFULL_BIT] = !buf_in_ready;
  end

  // Pick one answer per access:
  //   no byte lanes selected          error
  //   write to status or unmapped     error
  //   read of an unmapped index       error
  //   data write, buffer full         retry, nothing stored
  //   data read, source empty         retry, nothing taken
  //   status read                     acknowledge
  //   data access that can proceed    acknowledge
  // Retrying rather than waiting keeps a stalled stream from holding
  // the bus, at the price of the master polling
  always_comb begin
    resp = RESP_NONE;
    if (hit) begin
      if (sel_i == '0) begin
        resp = RESP_ERR;
      end else if (is_data && we_i) begin
        resp = buf_in_ready ? RESP_ACK : RESP_RTY;
      end else if (is_data && !we_i) begin
        resp = rx_valid ? RESP_ACK : RESP_RTY;
      end else if (is_stat && !we_i) begin
        resp = RESP_ACK;
      end else begin
        resp = RESP_ERR;
      end
    end
  end

  // Push and pop only on an acknowledged access, so retries lose nothing;
  // both act at the same edge that takes the strobe
  assign buf_in_valid = (resp == RESP_ACK) && is_data && we_i;
  assign buf_in_data  = {tag_i, sel_i, dat_i & lane_mask(sel_i)};
  assign rx_ready     = rd_ack && is_data;
  assign rd_ack       = (resp == RESP_ACK) && !we_i;

  // Answer timing, one access:
  //   edge 0  strobe taken while idle; push or pull happens here
  //   after   one termination shows for one cycle, read data in place
  //   edge 1  master sees the termination; a strobe still high here
  //           is not taken again, so back-to-back accesses cost two cycles
  //   write   word sits in the buffer when the ack shows
  //   read    rx_ready is high in the cycle before edge 0
  // Bus reset returns the sequencer to idle at the edge that sees it
  always_comb begin
    state_nxt = state_r;
    ack_nxt   = RST_TERM;
    err_nxt   = RST_TERM;
    rty_nxt   = RST_TERM;
    if (rst_i) begin
      state_nxt = ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (hit) begin
            state_nxt = ST_TERM;
            ack_nxt   = (resp == RESP_ACK);
            err_nxt   = (resp == RESP_ERR);
            rty_nxt   = (resp == RESP_RTY);
          end
        end
        ST_TERM: begin
          state_nxt = ST_IDLE;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // Every bus output leaves a flip-flop on the rising edge;
  // no gates sit between these flops and the termination pins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      ack_r   <= RST_TERM;
      err_r   <= RST_TERM;
      rty_r   <= RST_TERM;
    end else begin
      state_r <= state_nxt;
      ack_r   <= ack_nxt;
      err_r   <= err_nxt;
      rty_r   <= rty_nxt;
    end
  end

  // Read data and tag stand until the next acknowledged read, so a
  // retried or refused access leaves the last good word in place;
  // the bus reset clears them but leaves the rest of the core alone
  always_comb begin
    dat_nxt = dat_r;
    tag_nxt = tag_r;
    if (rst_i) begin
      dat_nxt = '0;
      tag_nxt = '0;
    end else if (rd_ack) begin
      if (is_data) begin
        dat_nxt = rx_data & lane_mask(sel_i);
        tag_nxt = rx_tag;
      end else begin
        dat_nxt = stat_word & lane_mask(sel_i);
        tag_nxt = '0;
      end
    end
  end

  // Read data registers; the async reset clears them with the rest
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dat_r <= '0;
      tag_r <= '0;
    end else begin
      dat_r <= dat_nxt;
      tag_r <= tag_nxt;
    end
  end

  // Outputs straight from the registers, no logic after them,
  // so the answer paths stay short
  assign ack_o = ack_r;
  assign err_o = err_r;
  assign rty_o = rty_r;
  assign dat_o = dat_r;
  assign tag_o = tag_r;

  // Write buffer: a stalled stream consumer fills it, then writes retry.
  // Two entries let one bus write land while the consumer takes the
  // previous word; the bus reset flushes it, the async reset clears it
  stream_buf #(
    .W     (BUF_W),
    .DEPTH (BUF_DEPTH),
    .CNT_W (BUF_CNT_W)
  ) u_tx_buf (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .flush     (rst_i),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (buf_out_data),
    .level     (buf_level)
  );

  // Split buffered word back into data, lanes and tag;
  // packed as tag, lanes, data from the top down
  assign tx_data = buf_out_data[DAT_W-1:0];
  assign tx_sel  = buf_out_data[DAT_W +: SEL_W];
  assign tx_tag  = buf_out_data[DAT_W+SEL_W +: TAG_W];

endmodule

/* File: bus_port_checker.sv */
// Protocol checker for the bus slave stream port
`timescale 1ns/1ns
module bus_port_checker #(
  parameter int DAT_W = 32,
  parameter int SEL_W = 4
) (
  input wire logic             core_clk,
  input wire logic             rst_b,
  input wire logic             rst_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic             rx_valid,
  input wire logic [DAT_W-1:0] rx_data,
  input wire logic             ack_o,
  input wire logic             err_o,
  input wire logic             rty_o,
  input wire logic [DAT_W-1:0] dat_o,
  input wire logic             tx_valid,
  input wire logic             rx_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // A request is only taken while no termination is showing
  wire term = ack_o | err_o | rty_o;
  wire take = cyc_i & stb_i & ~rst_i & ~term;
  chk_single_term: assert property ($onehot0({ack_o, err_o, rty_o}))
    else $error("two terminations at once");
  chk_strobe_answered: assert property (take |=> term)
    else $error("strobe left unanswered");
  chk_unselected_quiet: assert property ((!(cyc_i && stb_i) || rst_i) |=> !term)
    else $error("termination without a strobe");
  chk_term_one_cycle: assert property (term |=> !term)
    else $error("termination longer than one cycle");
  chk_bus_reset: assert property (rst_i |=> !term && !tx_valid && dat_o == '0)
    else $error("bus reset did not clear the port");
  chk_write_fills: assert property (ack_o && $past(we_i) |-> tx_valid)
    else $error("acked write not buffered");
  chk_read_pulls: assert property (rx_ready |-> stb_i && !we_i && rx_valid && !term)
    else $error("stream word taken outside a read");
  chk_read_lane: assert property (rx_ready && sel_i[0] |=> ack_o && dat_o[7:0] == $past(rx_data[7:0]))
    else $error("read lane data wrong");
  chk_zero_sel: assert property (take && sel_i == '0 |=> err_o)
    else $error("empty select not refused");
  chk_data_holds: assert property (!ack_o && !$past(rst_i) |-> $stable(dat_o))
    else $error("read data moved without an ack");
endmodule
bind bus_slave_port bus_port_checker #(.DAT_W(DAT_W), .SEL_W(SEL_W)) i_bus_port_checker (
  .core_clk, .rst_b, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .rx_valid, .rx_data,
  .ack_o, .err_o, .rty_o, .dat_o, .tx_valid, .rx_ready);

/* File: bus_master_model.sv */
// Behavioural bus master that runs one transfer per call
`timescale 1ns/1ns
module bus_master_model #(
  parameter int DAT_W = 32,
  parameter int ADR_W = 8,
  parameter int SEL_W = 4
) (
  input  wire logic             core_clk,
  output logic                  cyc,
  output logic                  stb,
  output logic                  we,
  output logic      [ADR_W-1:0] adr,
  output logic      [DAT_W-1:0] dat,
  output logic      [SEL_W-1:0] sel,
  output logic                  tag,
  input  wire logic             ack,
  input  wire logic             err,
  input  wire logic             rty,
  input  wire logic [DAT_W-1:0] rdata
);
  // Quiet bus from time zero, so reset finds strobe and cycle low
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    {we, adr, dat, sel, tag} = '0;
  end
  // Hold the request until a termination is sampled or 8 cycles pass, then let go
  task automatic xfer(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
                      input logic [SEL_W-1:0] s, output logic [2:0] t,
                      output logic [DAT_W-1:0] q);
    int n;
    @(posedge core_clk);
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    tag <= d[0];
    do begin
      @(posedge core_clk);
      n++;
    end while (!(ack | err | rty) && n < 8);
    t = {ack, err, rty};
    q = rdata;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released lines other than tag show junk, never the old value; tag keeps it
    {we, adr, dat, sel} <= ~{w, a, d, s};
  endtask
endmodule

/* File: bus_slave_port_tb.sv */
// Self-checking bench for the bus slave stream port
`timescale 1ns/1ns
module bus_slave_port_tb;
  import bus_port_pkg::*;
  localparam logic [7:0] A_DAT = 8'(DATA_IDX * 4);
  localparam logic [7:0] A_STA = 8'(STAT_IDX * 4);
  localparam logic [7:0] A_BAD = 8'h08;
  logic        core_clk, rst_b, rst_i, cyc, stb, we, tag, ack, err, rty, tag_o, tx_tag;
  logic        tx_valid, tx_ready, rx_valid, rx_ready, rx_tag;
  logic [7:0]  adr;
  logic [3:0]  sel, tx_sel;
  logic [2:0]  t;
  logic [31:0] dat, rdata, tx_data, rx_data, q;
  int          fails = 0;
  int          total_checks = 0;
  bus_slave_port i_bus_slave_port (
    .core_clk, .rst_b, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat),
    .sel_i(sel), .tag_i(tag), .ack_o(ack), .err_o(err), .rty_o(rty), .dat_o(rdata), .tag_o,
    .tx_valid, .tx_ready, .tx_data, .tx_sel, .tx_tag, .rx_valid, .rx_ready, .rx_data, .rx_tag);
  bus_master_model i_bus_master_model (
    .core_clk, .cyc, .stb, .we, .adr, .dat, .sel, .tag, .ack, .err, .rty, .rdata);
  // One clock shared by master and slave
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Fill the buffer to refusal with the consumer stalled, then drain it
  task automatic t_write();
    i_bus_master_model.xfer(1'b1, A_DAT, 32'hA1B2C3D5, 4'hF, t, q);
    chk("write term", 3'b100, t);
    i_bus_master_model.xfer(1'b1, A_DAT, 32'h55667788, 4'h3, t, q);
    chk("second term", 3'b100, t);
    i_bus_master_model.xfer(1'b1, A_DAT, 32'h0, 4'hF, t, q);
    chk("full term", 3'b001, t);
    i_bus_master_model.xfer(1'b0, A_STA, 32'h0, 4'hF, t, q);
    chk("status", 32'(2 << STAT_TXCNT_LSB | 1 << STAT_TXFULL_BIT), q);
    chk("head word", 32'hA1B2C3D5, tx_data);
    chk("head tag", 1'b1, tx_tag);
    @(posedge core_clk) tx_ready <= 1'b1;
    @(posedge core_clk);
    #1 chk("masked word", 32'h00007788, tx_data);
    chk("masked sel", 4'h3, tx_sel);
    @(posedge core_clk);
    #1 chk("drained", 1'b0, tx_valid);
    $display("test write done");
  endtask
  // Read from an empty stream, then a lane-masked read
  task automatic t_read();
    i_bus_master_model.xfer(1'b0, A_DAT, 32'h0, 4'hF, t, q);
    chk("empty term", 3'b001, t);
    @(posedge core_clk);
    {rx_valid, rx_tag, rx_data} <= {2'b11, 32'h13579BDF};
    i_bus_master_model.xfer(1'b0, A_DAT, 32'h0, 4'h5, t, q);
    {rx_valid, rx_data} <= {1'b0, 32'hECA86420};
    chk("read term", 3'b100, t);
    chk("read lanes", 32'h005700DF, q);
    #1 chk("read tag", 1'b1, tag_o);
    $display("test read done");
  endtask
  // Refused accesses end in error and leave no trace
  task automatic t_errors();
    @(posedge core_clk) tx_ready <= 1'b0;
    i_bus_master_model.xfer(1'b1, A_DAT, 32'h1, 4'h0, t, q);
    chk("no lanes", 3'b010, t);
    i_bus_master_model.xfer(1'b1, A_STA, 32'h1, 4'hF, t, q);
    chk("status write", 3'b010, t);
    i_bus_master_model.xfer(1'b0, A_BAD, 32'h0, 4'hF, t, q);
    chk("unmapped read", 3'b010, t);
    #1 chk("no push", 1'b0, tx_valid);
    $display("test errors done");
  endtask
  // Bus reset mid-run clears the port; first request after it is served
  task automatic t_reset();
    i_bus_master_model.xfer(1'b1, A_DAT, 32'h9, 4'hF, t, q);
    @(posedge core_clk) rst_i <= 1'b1;
    @(posedge core_clk) rst_i <= 1'b0;
    #1 chk("flushed", 1'b0, tx_valid);
    chk("data cleared", 32'h0, rdata);
    chk("tag cleared", 1'b0, tag_o);
    i_bus_master_model.xfer(1'b1, A_DAT, 32'h2, 4'hF, t, q);
    chk("after reset", 3'b100, t);
    $display("test reset done");
  endtask
  // Main sequence
  initial begin
    {rst_b, rst_i, tx_ready, rx_valid, rx_tag, rx_data} = {4'b0100, 33'h0};
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    rst_i <= 1'b0;
    t_write();
    t_read();
    t_errors();
    t_reset();
    end_of_test();
  end
  // Hang guard, well past the roughly 50 cycles the tests need
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    end_of_test();
  end
endmodule
